/* File: hw/dbpf_rx.sv */
// Receiver that unpacks data blocks from page data packets.
// Assumes packet and byte strobes come from hclk logic,
// one event per cycle, and an AHB-Lite master with no waits.
`timescale 1ns/1ns
module dbpf_rx (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic hdr_valid,
   input wire logic [3:0] stream_identifier,
   input wire logic [2:0] last_packet_low_bits,
   input wire logic [1:0] last_packet_high_bits,
   input wire logic p28_valid,
   input wire logic [17:0] p28_triplet,
   input wire logic pkt_valid,
   input wire logic [4:0] pkt_addr,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic blk_start,
   output logic [4:0] blk_app_id,
   output logic [10:0] blk_count,
   output logic blk_sinfo,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   output logic pkt_loss
);
   import dbpf_pkg::*;

   logic [31:0] ctrl_q;
   logic [31:0] rdata_q;
   logic [15:0] cnt_q [4];
   logic [3:0] inc;
   logic [3:0] clr;
   logic wr_q;
   logic [7:0] wa_q;
   logic [7:0] ra;
   logic [31:0] rd_d;
   logic ahb_take;

   logic [3:0] s_q;
   logic s_ok_q;
   logic act_q;
   logic [5:0] pos_q;
   logic [3:0] bp_q;
   dbpf_mode_e mode_q [16];
   logic [10:0] rem_q [16];
   logic [11:0] hdr_q [16];
   logic [1:0] hcnt_q [16];
   logic [4:0] exp_q [16];
   logic [4:0] last_q [16];
   logic p28_q [16];

   dbpf_mode_e mode_cur;
   dbpf_mode_e mode_d;
   logic [10:0] rem_d;
   logic [11:0] hdr_d;
   logic [1:0] hcnt_d;
   logic [15:0] full;
   logic [3:0] nib;
   logic bad;
   logic sep_here;
   logic at_ptr;
   logic [5:0] ptr_pos;
   logic [4:0] max_addr;
   logic hdr_take;
   logic p28_take;
   logic p28_ok;
   logic pkt_take;
   logic pkt_rng;
   logic pkt_gap;
   logic hdr_gap;
   logic byte_take;
   logic blk_ev;
   logic dat_ev;
   logic last_ev;
   logic resync_ev;

   dbpf_ham84 u_ham (
      .code(byte_data),
      .nib(nib),
      .bad(bad)
   );

   // Stall the bus while the block is frozen
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   assign mode_cur = mode_q[s_q];
   assign max_addr = p28_q[s_q] ? DBPF_MAX_P28 : DBPF_MAX_STD;
   assign hdr_take = hdr_valid && ctrl_q[DBPF_CTRL_EN_BIT];
   assign p28_take = p28_valid && s_ok_q;
   assign p28_ok = p28_triplet[3:0] == DBPF_P28_FUNC && p28_triplet[6:4] == DBPF_P28_CODE
      && p28_triplet[16:7] == DBPF_P28_TAIL;
   assign pkt_take = pkt_valid && s_ok_q;
   assign pkt_rng = pkt_addr == 5'h00 || pkt_addr > max_addr;
   assign pkt_gap = !pkt_rng && pkt_addr != exp_q[s_q];
   // Short page: packets after the last one seen never came
   assign hdr_gap = exp_q[stream_identifier] != 5'h00
      && exp_q[stream_identifier] != 5'(last_q[stream_identifier] + 5'h01);
   assign byte_take = byte_valid && act_q && pos_q < DBPF_PKT_BYTES;
   // Separator is a coded byte, so one bit error is tolerated
   assign sep_here = !bad && nib == DBPF_SEP_NIB;
   assign ptr_pos = 6'(6'(bp_q) * 6'h03 + 6'h01);
   assign at_ptr = bp_q <= DBPF_BP_MAX && pos_q == ptr_pos;
   assign full = {nib, hdr_q[s_q]};

   // Block assembly for one byte of the current stream
   always_comb begin
      mode_d = mode_cur;
      rem_d = rem_q[s_q];
      hdr_d = hdr_q[s_q];
      hcnt_d = hcnt_q[s_q];
      blk_ev = 1'b0;
      dat_ev = 1'b0;
      last_ev = 1'b0;
      resync_ev = 1'b0;
      if (pos_q == 6'h00) begin
         mode_d = mode_cur;
      end else if (at_ptr) begin
         // The pointer outranks the running count
         if (sep_here) begin
            resync_ev = mode_cur == DBPF_DATA || mode_cur == DBPF_HDR;
            mode_d = DBPF_HDR;
            hcnt_d = 2'h0;
         end else begin
            resync_ev = mode_cur != DBPF_HUNT;
            mode_d = DBPF_HUNT;
         end
      end else begin
         case (mode_cur)
            DBPF_GAP: begin
               if (sep_here) begin
                  mode_d = DBPF_HDR;
                  hcnt_d = 2'h0;
               end else if (byte_data != DBPF_FILL) begin
                  mode_d = DBPF_HUNT;
               end
            end
            DBPF_HDR: begin
               if (bad) begin
                  mode_d = DBPF_HUNT;
               end else if (hcnt_q[s_q] == 2'h3) begin
                  // First nibble is id[3:0], then id[4] in bit 0
                  blk_ev = 1'b1;
                  rem_d = full[15:5];
                  mode_d = full[15:5] == 11'h000 ? DBPF_GAP : DBPF_DATA;
               end else begin
                  hdr_d[{hcnt_q[s_q], 2'b00} +: 4] = nib;
                  hcnt_d = 2'(hcnt_q[s_q] + 2'h1);
               end
            end
            DBPF_DATA: begin
               dat_ev = 1'b1;
               rem_d = 11'(rem_q[s_q] - 11'h001);
               if (rem_q[s_q] == 11'h001) begin
                  last_ev = 1'b1;
                  mode_d = DBPF_GAP;
               end
            end
            default: begin
               mode_d = DBPF_HUNT;
            end
         endcase
      end
   end

   // Per-stream assembly state, kept across pages
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 16; i++) begin
            mode_q[i] <= DBPF_HUNT;
            rem_q[i] <= 11'h000;
            hdr_q[i] <= 12'h000;
            hcnt_q[i] <= 2'h0;
            exp_q[i] <= 5'h00;
            last_q[i] <= 5'h00;
            p28_q[i] <= 1'b0;
         end
      end else if (ce) begin
         if (hdr_take) begin
            exp_q[stream_identifier] <= 5'h01;
            last_q[stream_identifier] <= {last_packet_high_bits, last_packet_low_bits};
            p28_q[stream_identifier] <= 1'b0;
            if (hdr_gap) begin
               mode_q[stream_identifier] <= DBPF_HUNT;
            end
         end else if (p28_take) begin
            p28_q[s_q] <= p28_ok;
         end else if (pkt_take) begin
            exp_q[s_q] <= pkt_rng ? exp_q[s_q] : 5'(pkt_addr + 5'h01);
            if (pkt_gap) begin
               mode_q[s_q] <= DBPF_HUNT;
            end
         end else if (byte_take) begin
            mode_q[s_q] <= mode_d;
            rem_q[s_q] <= rem_d;
            hdr_q[s_q] <= hdr_d;
            hcnt_q[s_q] <= hcnt_d;
         end
      end
   end

   // Packet tracking for the stream of the last header
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= 4'h0;
         s_ok_q <= 1'b0;
         act_q <= 1'b0;
         pos_q <= 6'h00;
         bp_q <= DBPF_BP_NONE;
      end else if (ce) begin
         if (hdr_take) begin
            s_q <= stream_identifier;
            s_ok_q <= ctrl_q[DBPF_CTRL_MASK_LSB + 32'(stream_identifier)];
            act_q <= 1'b0;
         end else if (hdr_valid) begin
            s_ok_q <= 1'b0;
            act_q <= 1'b0;
         end else if (pkt_take) begin
            act_q <= !pkt_rng;
            pos_q <= 6'h00;
         end else if (byte_take) begin
            pos_q <= 6'(pos_q + 6'h01);
            if (pos_q == 6'h00) begin
               // Unreadable pointer falls back to the running count
               bp_q <= bad ? DBPF_BP_NONE : nib;
            end
         end
      end
   end

   // Outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blk_start <= 1'b0;
         blk_app_id <= 5'h00;
         blk_count <= 11'h000;
         blk_sinfo <= 1'b0;
         out_valid <= 1'b0;
         out_data <= 8'h00;
         out_last <= 1'b0;
         pkt_loss <= 1'b0;
      end else if (ce) begin
         blk_start <= byte_take && blk_ev;
         out_valid <= byte_take && dat_ev;
         out_last <= byte_take && last_ev;
         pkt_loss <= (pkt_take && pkt_gap) || (hdr_take && hdr_gap);
         if (byte_take && blk_ev) begin
            blk_app_id <= full[4:0];
            blk_count <= full[15:5];
            blk_sinfo <= full[4:0] == DBPF_APPID_SINFO;
         end
         if (byte_take && dat_ev) begin
            out_data <= byte_data;
         end
      end
   end

   // Event counters: loss, resync, blocks, out of range
   assign inc[0] = (pkt_take && pkt_gap) || (hdr_take && hdr_gap);
   assign inc[1] = byte_take && resync_ev;
   assign inc[2] = byte_take && blk_ev;
   assign inc[3] = pkt_take && pkt_rng;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 4; i++) begin
            cnt_q[i] <= 16'h0000;
         end
      end else if (ce) begin
         for (int i = 0; i < 4; i++) begin
            // An event in the clearing cycle is kept
            if (clr[i]) begin
               cnt_q[i] <= {15'h0000, inc[i]};
            end else if (inc[i] && cnt_q[i] != 16'hFFFF) begin
               cnt_q[i] <= 16'(cnt_q[i] + 16'h0001);
            end
         end
      end
   end

   // AHB-Lite slave, zero wait states while ce is high
   assign ahb_take = hsel && htrans[1] && hready;
   assign ra = haddr[7:0];

   always_comb begin
      rd_d = 32'h0000_0000;
      clr = 4'h0;
      if (ra == DBPF_OFS_CTRL) begin
         rd_d = ctrl_q;
      end else if (ra == DBPF_OFS_STAT) begin
         rd_d = {24'h00_0000, p28_q[s_q], mode_cur, act_q, s_q};
      end else if (ra >= DBPF_OFS_CNT0 && ra <= DBPF_OFS_CNT3 && ra[1:0] == 2'b00) begin
         rd_d = {16'h0000, cnt_q[2'(ra[4:2] - 3'h2)]};
      end
      if (wr_q && wa_q >= DBPF_OFS_CNT0 && wa_q <= DBPF_OFS_CNT3) begin
         clr[2'(wa_q[4:2] - 3'h2)] = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         wr_q <= ahb_take && hwrite;
         if (ahb_take) begin
            wa_q <= ra;
            rdata_q <= hwrite ? 32'h0000_0000 : rd_d;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= DBPF_CTRL_RST;
      end else if (ce && wr_q && wa_q == DBPF_OFS_CTRL) begin
         ctrl_q <= hwdata & DBPF_CTRL_WMASK;
      end
   end

   default clocking dbpf_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_RANGE_DROP: assert property (ce && pkt_take && pkt_rng |=> !act_q)
      else $error("out of range packet was accepted");
   AST_PTR_NOT_DATA: assert property (ce && byte_take && pos_q == 6'h00 |=> !out_valid && !blk_start)
      else $error("pointer byte treated as payload");
   AST_HDR_FOURTH: assert property (blk_start |-> $past(mode_cur == DBPF_HDR) && $past(hcnt_q[s_q]) == 2'h3)
      else $error("block start without four header bytes");
   AST_SINFO: assert property (blk_start |-> blk_sinfo == (blk_app_id == DBPF_APPID_SINFO))
      else $error("service information flag wrong");
   AST_LAST_COUNT: assert property (out_last |-> out_valid && $past(rem_q[s_q]) == 11'h001)
      else $error("block ended before its count");
   AST_FILL_SCAN: assert property (ce && byte_take && mode_cur == DBPF_GAP && byte_data == DBPF_FILL
      && !at_ptr && pos_q != 6'h00 |=> !blk_start && !out_valid && mode_q[$past(s_q)] == DBPF_GAP)
      else $error("filler byte not skipped");
   AST_GAP_LOSS: assert property (ce && pkt_take && pkt_gap && !hdr_valid |=> pkt_loss)
      else $error("packet gap not flagged");
   AST_PAYLOAD: assert property (ce && byte_take && dat_ev |=> out_valid && out_data == $past(byte_data))
      else $error("payload byte altered");
   AST_RESYNC: assert property (ce && byte_take && at_ptr && sep_here && mode_cur == DBPF_DATA
      |=> mode_q[$past(s_q)] == DBPF_HDR && cnt_q[1] != 16'h0000)
      else $error("pointer separator did not resync");
endmodule : dbpf_rx

/* File: hw/dbpf_pkg.sv */
// Functional notes
// - data packets 1..23, or 1..25 with packet 28
// - byte 6 holds coded block pointer
// - fields least significant bit first
// - pointer 0..C locates separator; D none
// - header: 5-bit id then 11-bit count
// - application id 0 is service information
// - count excludes header, at most 2047
// - pointer, separator, count are Hamming coded
// - filler 5E, separator A1, mutual inverses
// - blocks and counts carry across pages
// - ascending packets; gaps flagged as loss
// - separate assembly state per stream
// - packet 28 triplet 1 fixed code check
// - filler where separator expected: scan forward
// - payload bytes pass unmodified, 8 bits
// - last packet from low and high bits
//
// Package for the page-format data block receiver.
// Assumes one AHB-Lite clock domain and 32-bit data.
package dbpf_pkg;
   localparam logic [7:0] DBPF_SEP = 8'hA1;
   localparam logic [7:0] DBPF_FILL = 8'h5E;
   localparam logic [3:0] DBPF_SEP_NIB = 4'hC;
   localparam logic [3:0] DBPF_BP_MAX = 4'hC;
   localparam logic [3:0] DBPF_BP_NONE = 4'hD;
   localparam logic [4:0] DBPF_MAX_STD = 5'h17;
   localparam logic [4:0] DBPF_MAX_P28 = 5'h19;
   localparam logic [5:0] DBPF_PKT_BYTES = 6'h28;
   localparam logic [4:0] DBPF_APPID_SINFO = 5'h00;
   localparam logic [3:0] DBPF_P28_FUNC = 4'h1;
   localparam logic [2:0] DBPF_P28_CODE = 3'h1;
   localparam logic [9:0] DBPF_P28_TAIL = 10'h3FC;
   localparam logic [7:0] DBPF_OFS_CTRL = 8'h00;
   localparam logic [7:0] DBPF_OFS_STAT = 8'h04;
   localparam logic [7:0] DBPF_OFS_CNT0 = 8'h08;
   localparam logic [7:0] DBPF_OFS_CNT3 = 8'h14;
   localparam int DBPF_CTRL_EN_BIT = 0;
   localparam int DBPF_CTRL_MASK_LSB = 16;
   localparam logic [31:0] DBPF_CTRL_RST = 32'hFFFF_0001;
   localparam logic [31:0] DBPF_CTRL_WMASK = 32'hFFFF_0001;
   typedef enum logic [1:0] {DBPF_HUNT, DBPF_HDR, DBPF_DATA, DBPF_GAP} dbpf_mode_e;
endpackage : dbpf_pkg

/* File: hw/dbpf_ham84.sv */
// Hamming 8/4 decoder with single-error correction.
// Assumes the byte is already in the hclk domain.
`timescale 1ns/1ns
module dbpf_ham84 (
   input wire logic [7:0] code,
   output logic [3:0] nib,
   output logic bad
);
   logic a;
   logic b;
   logic c;
   logic d;
   always_comb begin
      // Bit 1 is the first bit sent, held in code[0]
      a = code[0] ^ code[1] ^ code[5] ^ code[7];
      b = code[1] ^ code[2] ^ code[3] ^ code[7];
      c = code[1] ^ code[3] ^ code[4] ^ code[5];
      d = ^code;
      nib[0] = code[1] ^ (!a && !b && !c);
      nib[1] = code[3] ^ (a && !b && !c);
      nib[2] = code[5] ^ (!a && b && !c);
      nib[3] = code[7] ^ (!a && !b && c);
      // Any failed sub-check with good overall parity is a double error
      bad = !(a && b && c) && d;
   end
endmodule : dbpf_ham84

/* File: verif/dbpf_src.sv */
// Page inserter model driving the receiver's link strobes.
// Assumes the bench fills the per-stream queues and calls its tasks.
`timescale 1ns/1ns
module dbpf_src
   import dbpf_pkg::*;
(
   input wire logic hclk,
   output logic hdr_valid,
   output logic [3:0] stream_identifier,
   output logic [2:0] last_packet_low_bits,
   output logic [1:0] last_packet_high_bits,
   output logic p28_valid,
   output logic [17:0] p28_triplet,
   output logic pkt_valid,
   output logic [4:0] pkt_addr,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   logic [7:0] sq[16][$];
   bit ss[16][$];
   initial begin
      {hdr_valid, stream_identifier, last_packet_low_bits, last_packet_high_bits} = '0;
      {p28_valid, p28_triplet, pkt_valid, pkt_addr, byte_valid, byte_data} = '0;
   end
   function automatic logic [7:0] ham(input logic [3:0] n);
      logic p1, p2, p3, p4;
      p1 = ~(n[0] ^ n[2] ^ n[3]);
      p2 = ~(n[0] ^ n[1] ^ n[3]);
      p3 = ~(n[0] ^ n[1] ^ n[2]);
      p4 = ~(p1 ^ p2 ^ p3 ^ (^n));
      return {n[3], p4, n[2], p3, n[1], p2, n[0], p1};
   endfunction : ham
   task automatic strobe_hdr(input logic [3:0] s, input logic [4:0] last);
      @(posedge hclk);
      hdr_valid <= 1'b1;
      stream_identifier <= s;
      last_packet_low_bits <= last[2:0];
      last_packet_high_bits <= last[4:3];
      @(posedge hclk);
      hdr_valid <= 1'b0;
   endtask : strobe_hdr
   task automatic strobe_p28();
      @(posedge hclk);
      p28_valid <= 1'b1;
      p28_triplet <= {1'b0, DBPF_P28_TAIL, DBPF_P28_CODE, DBPF_P28_FUNC};
      @(posedge hclk);
      p28_valid <= 1'b0;
   endtask : strobe_p28
   task automatic send_pkt(input int s, input logic [4:0] a);
      logic [7:0] b[$];
      logic [3:0] bp;
      bp = DBPF_BP_NONE;
      for (int pos = 1; pos <= 39; pos++) begin
         if (sq[s].size() == 0 || (ss[s][0] && bp == DBPF_BP_NONE && pos % 3 != 1)) begin
            b.push_back(DBPF_FILL);
         end else begin
            if (ss[s][0] && bp == DBPF_BP_NONE) begin
               bp = 4'((pos - 1) / 3);
            end
            b.push_back(sq[s].pop_front());
            void'(ss[s].pop_front());
         end
      end
      @(posedge hclk);
      pkt_valid <= 1'b1;
      pkt_addr <= a;
      @(posedge hclk);
      pkt_valid <= 1'b0;
      byte_valid <= 1'b1;
      byte_data <= ham(bp);
      foreach (b[i]) begin
         @(posedge hclk);
         byte_data <= b[i];
      end
      @(posedge hclk);
      byte_valid <= 1'b0;
      byte_data <= ~b[38];
   endtask : send_pkt
endmodule : dbpf_src

/* File: verif/data_broadcast_packet_framer_test.sv */
// Self-checking bench for the block receiver with an inserter model.
// Assumes ce high except one short freeze, so the slave has no waits.
`timescale 1ns/1ns
module data_broadcast_packet_framer_test;
   import dbpf_pkg::*;
   logic hclk = 1'b0;
   logic ce;
   logic hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, rng;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, hdr_valid, p28_valid, pkt_valid, byte_valid;
   logic blk_start, blk_sinfo, out_valid, out_last, pkt_loss;
   logic [31:0] hrdata;
   logic [3:0] stream_identifier;
   logic [2:0] last_packet_low_bits;
   logic [1:0] last_packet_high_bits;
   logic [17:0] p28_triplet;
   logic [4:0] pkt_addr, blk_app_id;
   logic [7:0] byte_data, out_data;
   logic [10:0] blk_count;
   logic [16:0] e;
   logic [16:0] exq[16][$];
   int mismatches, tests_run, loss_seen, cur_s;
   always #4 hclk = ~hclk;
   dbpf_rx DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .hdr_valid(hdr_valid), .stream_identifier(stream_identifier),
      .last_packet_low_bits(last_packet_low_bits), .last_packet_high_bits(last_packet_high_bits),
      .p28_valid(p28_valid), .p28_triplet(p28_triplet), .pkt_valid(pkt_valid), .pkt_addr(pkt_addr),
      .byte_valid(byte_valid), .byte_data(byte_data), .blk_start(blk_start), .blk_app_id(blk_app_id),
      .blk_count(blk_count), .blk_sinfo(blk_sinfo), .out_valid(out_valid), .out_data(out_data),
      .out_last(out_last), .pkt_loss(pkt_loss));
   dbpf_src src (.hclk(hclk), .hdr_valid(hdr_valid), .stream_identifier(stream_identifier),
      .last_packet_low_bits(last_packet_low_bits), .last_packet_high_bits(last_packet_high_bits),
      .p28_valid(p28_valid), .p28_triplet(p28_triplet), .pkt_valid(pkt_valid), .pkt_addr(pkt_addr),
      .byte_valid(byte_valid), .byte_data(byte_data));
   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : rnd
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (ex !== got) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : ahb
   task automatic reg_chk(input string nm, input logic [31:0] a, input logic [31:0] ex);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(nm, ex, r);
   endtask : reg_chk
   task automatic gen_block(input int s, input logic [4:0] id, input logic [10:0] n, input bit track);
      logic [7:0] d;
      logic [15:0] h;
      h = {n, id};
      src.sq[s].push_back(DBPF_SEP);
      src.ss[s].push_back(1'b1);
      for (int k = 0; k < 4; k++) begin
         src.sq[s].push_back(src.ham(h[4*k +: 4]));
         src.ss[s].push_back(1'b0);
      end
      if (track) exq[s].push_back({1'b1, id, n});
      for (int k = 0; k < n; k++) begin
         d = 8'(rnd());
         src.sq[s].push_back(d);
         src.ss[s].push_back(1'b0);
         if (track) exq[s].push_back({8'h00, k == n - 1, d});
      end
   endtask : gen_block
   task automatic page(input int s, input logic [4:0] last, input bit p28);
      repeat (2) @(posedge hclk);
      cur_s = s;
      src.strobe_hdr(4'(s), last);
      if (p28) src.strobe_p28();
      for (int a = 1; a <= last; a++) src.send_pkt(s, 5'(a));
   endtask : page
   function automatic logic [16:0] exp_pop();
      if (exq[cur_s].size() == 0) return 17'h1FFFF;
      return exq[cur_s].pop_front();
   endfunction : exp_pop
   always @(posedge hclk) begin
      if (hresetn === 1'b1 && blk_start === 1'b1) begin
         e = exp_pop();
         chk("block header", 32'(e), {15'h0, 1'b1, blk_app_id, blk_count});
         chk("service info flag", 32'(e[15:11] == DBPF_APPID_SINFO), 32'(blk_sinfo));
      end
      if (hresetn === 1'b1 && out_valid === 1'b1) begin
         chk("payload", 32'(exp_pop()), {23'h0, out_last, out_data});
      end
      if (hresetn === 1'b1 && pkt_loss === 1'b1) loss_seen++;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      $display("unexpected watchdog expired");
      tally_and_finish();
   end
   initial begin
      logic [31:0] r;
      logic [15:0] h;
      {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
      ce = 1'b1;
      hsize = 3'h2;
      rng = 32'h5D7D;
      {mismatches, tests_run, loss_seen, cur_s} = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      reg_chk("control reset", 32'(DBPF_OFS_CTRL), DBPF_CTRL_RST);
      reg_chk("unmapped", 32'h40, 32'h0);
      chk("response", 32'h0, 32'(hresp));
      gen_block(1, DBPF_APPID_SINFO, 11'd3, 1);
      gen_block(1, 5'd5, 11'd2047, 1);
      for (int k = 0; k < 6; k++) gen_block(1, 5'(rnd()), 11'(rnd() % 40), 1);
      page(1, 5'd23, 0);
      gen_block(3, 5'd9, 11'd0, 1);
      gen_block(3, 5'd17, 11'd50, 1);
      page(3, 5'd4, 0);
      page(1, 5'd23, 0);
      page(1, 5'd25, 1);
      ahb(1'b1, 32'(DBPF_OFS_CTRL), 32'hFFDF_0001, r);
      gen_block(5, 5'd2, 11'd10, 0);
      page(5, 5'd2, 0);
      reg_chk("control", 32'(DBPF_OFS_CTRL), 32'hFFDF_0001);
      // Header claims 60 bytes but only 3 follow; the pointer must win
      h = {11'd60, 5'd4};
      src.sq[9].push_back(DBPF_SEP);
      src.ss[9].push_back(1'b1);
      for (int k = 0; k < 4; k++) begin
         src.sq[9].push_back(src.ham(h[4*k +: 4]));
         src.ss[9].push_back(1'b0);
      end
      for (int k = 0; k < 3; k++) begin
         src.sq[9].push_back(8'(rnd()));
         src.ss[9].push_back(1'b0);
      end
      exq[9].push_back({1'b1, h[4:0], h[15:5]});
      gen_block(9, 5'd6, 11'd30, 0);
      // Everything before the pointed separator comes out as payload
      for (int k = 5; k <= 42; k++) exq[9].push_back({9'h000, src.sq[9][k]});
      repeat (2) exq[9].push_back({9'h000, DBPF_FILL});
      gen_block(9, 5'd8, 11'd5, 1);
      page(9, 5'd2, 0);
      repeat (2) @(posedge hclk);
      cur_s = 7;
      src.strobe_hdr(4'h7, 5'd2);
      src.send_pkt(7, 5'd1);
      src.send_pkt(7, 5'd2);
      src.send_pkt(7, 5'd0);
      src.send_pkt(7, 5'd24);
      src.strobe_hdr(4'h7, 5'd3);
      src.send_pkt(7, 5'd1);
      src.strobe_hdr(4'h7, 5'd3);
      src.send_pkt(7, 5'd1);
      src.send_pkt(7, 5'd3);
      repeat (4) @(posedge hclk);
      chk("loss pulses", 32'd2, 32'(loss_seen));
      reg_chk("loss count", 32'(DBPF_OFS_CNT0), 32'd2);
      reg_chk("status", 32'(DBPF_OFS_STAT), 32'h17);
      reg_chk("resync count", 32'h0C, 32'd1);
      reg_chk("block count", 32'h10, 32'd12);
      reg_chk("range count", 32'(DBPF_OFS_CNT3), 32'd2);
      ahb(1'b1, 32'(DBPF_OFS_CNT0), 32'h0, r);
      reg_chk("loss cleared", 32'(DBPF_OFS_CNT0), 32'd0);
      // Freeze: the bus must stall while ce is low
      ce <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("stalled ready", 32'h0, 32'(hreadyout));
      ce <= 1'b1;
      for (int s = 0; s < 16; s++) chk("leftover", 32'd0, 32'(exq[s].size()));
      tally_and_finish();
   end
endmodule : data_broadcast_packet_framer_test
